// >>> hdl/qpip_defines.svh
// Constants for the quad phase instruction pipeline.
// Assumes inclusion by bare name from every file that needs them.
`ifndef QPIP_DEFINES_SVH
`define QPIP_DEFINES_SVH

// ==========================================================================
// Widths
`define QPIP_INSTR_W 14
`define QPIP_DATA_W 8
`define QPIP_PC_W 11
`define QPIP_FADDR_W 7
`define QPIP_SP_W 3
`define QPIP_STACK_DEPTH 8

// ==========================================================================
// Phase codes
`define QPIP_PH_ONE 2'h0
`define QPIP_PH_TWO 2'h1
`define QPIP_PH_THREE 2'h2
`define QPIP_PH_FOUR 2'h3

// ==========================================================================
// Opcode fields
`define QPIP_CLASS_HI 13
`define QPIP_CLASS_LO 11
`define QPIP_OPC_GOTO 3'h5
`define QPIP_OPC_CALL 3'h4
`define QPIP_OPC_RETURN 14'h0008
`define QPIP_OPC_NOP 14'h0000
`define QPIP_FILEOP_HI 13
`define QPIP_FILEOP_LO 12
`define QPIP_FILEOP 2'h0
`define QPIP_DEST_BIT 7
`define QPIP_FADDR_HI 6
`define QPIP_TARGET_HI 10

// ==========================================================================
// Reset values and steps
`define QPIP_PC_RST 11'h000
`define QPIP_PC_STEP 11'h001
`define QPIP_SP_RST 3'h0
`define QPIP_SP_STEP 3'h1
`define QPIP_DATA_STEP 8'h01
`define QPIP_DATA_RST 8'h00
`define QPIP_FADDR_RST 7'h00

`endif

// >>> hdl/qpip_pkg.sv
// Types for the quad phase instruction pipeline.
// Assumes qpip_defines.svh is on the include path.
`include "qpip_defines.svh"

package qpip_pkg;

  // ========================================================================
  // Phase of the instruction cycle
  typedef enum logic [1:0] {
    PH_ONE = `QPIP_PH_ONE,
    PH_TWO = `QPIP_PH_TWO,
    PH_THREE = `QPIP_PH_THREE,
    PH_FOUR = `QPIP_PH_FOUR
  } qpip_phase_type;

endpackage

// >>> hdl/qpip_pipeline.sv
// Two stage fetch/execute sequencer of a small 8-bit Harvard core.
// Assumes program and data memories on the same clock with combinational
// read data, and the oscillator clock arriving as clk.
`timescale 1ns/1ns
`include "qpip_defines.svh"

module qpip_pipeline (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // Phase clocks
  output logic phaseOne,
  output logic phaseTwo,
  output logic phaseThree,
  output logic phaseFour,
  // Program memory
  output logic [`QPIP_PC_W-1:0] progAddr,
  input wire logic [`QPIP_INSTR_W-1:0] progData,
  // Data memory
  output logic [`QPIP_FADDR_W-1:0] dataAddr,
  output logic dataRdEn,
  input wire logic [`QPIP_DATA_W-1:0] dataRdData,
  output logic dataWrEn,
  output logic [`QPIP_DATA_W-1:0] dataWrData,
  // Status
  output logic execValid,
  output logic [`QPIP_INSTR_W-1:0] execOpcode
);

  // ========================================================================
  // Declarations
  qpip_pkg::qpip_phase_type phase_ff;
  qpip_pkg::qpip_phase_type nxt_phase;
  logic [`QPIP_PC_W-1:0] pc_ff;
  logic [`QPIP_PC_W-1:0] fetchAddr_ff;
  logic [`QPIP_INSTR_W-1:0] fetchedOpcodeLatch_ff;
  logic [`QPIP_INSTR_W-1:0] execOpcode_ff;
  logic execValid_ff;
  logic flush_ff;
  logic [`QPIP_FADDR_W-1:0] dataAddr_ff;
  logic [`QPIP_DATA_W-1:0] operand_ff;
  logic [`QPIP_DATA_W-1:0] dataWrData_ff;
  logic [`QPIP_PC_W-1:0] stackMem_ff [0:`QPIP_STACK_DEPTH-1];
  logic [`QPIP_SP_W-1:0] sp_ff;
  logic [`QPIP_SP_W-1:0] spTop;
  logic isGoto;
  logic isCall;
  logic isReturn;
  logic writesFile;
  logic branchTaken;
  logic [`QPIP_PC_W-1:0] branchTarget;
  logic atOne;
  logic atTwo;
  logic atThree;
  logic atFour;

  // ========================================================================
  // Phase generator
  always_comb begin
    unique case (phase_ff)
      qpip_pkg::PH_ONE: nxt_phase = qpip_pkg::PH_TWO;
      qpip_pkg::PH_TWO: nxt_phase = qpip_pkg::PH_THREE;
      qpip_pkg::PH_THREE: nxt_phase = qpip_pkg::PH_FOUR;
      qpip_pkg::PH_FOUR: nxt_phase = qpip_pkg::PH_ONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_ff <= qpip_pkg::PH_ONE;
    end else if (clkEn) begin
      phase_ff <= nxt_phase;
    end
  end

  assign phaseOne = (phase_ff == qpip_pkg::PH_ONE);
  assign phaseTwo = (phase_ff == qpip_pkg::PH_TWO);
  assign phaseThree = (phase_ff == qpip_pkg::PH_THREE);
  assign phaseFour = (phase_ff == qpip_pkg::PH_FOUR);

  // Edge qualifiers: a phase takes effect on the clock edge that ends it.
  assign atOne = clkEn && phaseOne;
  assign atTwo = clkEn && phaseTwo;
  assign atThree = clkEn && phaseThree;
  assign atFour = clkEn && phaseFour;

  // ========================================================================
  // Decode of the executing word
  assign isGoto = (execOpcode_ff[`QPIP_CLASS_HI:`QPIP_CLASS_LO] == `QPIP_OPC_GOTO);
  assign isCall = (execOpcode_ff[`QPIP_CLASS_HI:`QPIP_CLASS_LO] == `QPIP_OPC_CALL);
  assign isReturn = (execOpcode_ff == `QPIP_OPC_RETURN);
  assign writesFile = execValid_ff
    && (execOpcode_ff[`QPIP_FILEOP_HI:`QPIP_FILEOP_LO] == `QPIP_FILEOP)
    && execOpcode_ff[`QPIP_DEST_BIT]
    && !isReturn
    && (execOpcode_ff != `QPIP_OPC_NOP);
  assign branchTaken = execValid_ff && (isGoto || isCall || isReturn);
  assign spTop = sp_ff - `QPIP_SP_STEP;
  assign branchTarget = isReturn ? stackMem_ff[spTop]
                                 : execOpcode_ff[`QPIP_TARGET_HI:0];

  // ========================================================================
  // Program counter and fetch address
  // The counter always holds the next word to fetch; the address on the
  // program bus is the word fetched in the current cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_ff <= `QPIP_PC_RST;
      fetchAddr_ff <= `QPIP_PC_RST;
    end else if (atOne) begin
      fetchAddr_ff <= pc_ff;
      pc_ff <= pc_ff + `QPIP_PC_STEP;
    end else if (atFour && branchTaken) begin
      pc_ff <= branchTarget;
    end
  end

  assign progAddr = fetchAddr_ff;

  // ========================================================================
  // Fetched opcode latch
  always_ff @(posedge clk) begin
    if (reset) begin
      fetchedOpcodeLatch_ff <= `QPIP_OPC_NOP;
    end else if (atFour) begin
      fetchedOpcodeLatch_ff <= progData;
    end
  end

  // ========================================================================
  // Execute stage and squash
  // A branch resolves in phase four, when the sequential word has already been fetched and is
  // latched on the same edge; that word is kept but marked invalid so it does nothing.
  always_ff @(posedge clk) begin
    if (reset) begin
      execOpcode_ff <= `QPIP_OPC_NOP;
      execValid_ff <= 1'b0;
    end else if (atOne) begin
      execOpcode_ff <= fetchedOpcodeLatch_ff;
      execValid_ff <= !flush_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flush_ff <= 1'b1;
    end else if (atFour && branchTaken) begin
      flush_ff <= 1'b1;
    end else if (atOne) begin
      flush_ff <= 1'b0;
    end
  end

  assign execValid = execValid_ff;
  assign execOpcode = execOpcode_ff;

  // ========================================================================
  // Data memory access
  always_ff @(posedge clk) begin
    if (reset) begin
      dataAddr_ff <= `QPIP_FADDR_RST;
    end else if (atOne) begin
      dataAddr_ff <= fetchedOpcodeLatch_ff[`QPIP_FADDR_HI:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      operand_ff <= `QPIP_DATA_RST;
    end else if (atTwo) begin
      operand_ff <= dataRdData;
    end
  end

  // The file operation here is a plain increment; the result is registered at
  // the end of phase three, as the write strobe rises, and holds through phase four.
  always_ff @(posedge clk) begin
    if (reset) begin
      dataWrData_ff <= `QPIP_DATA_RST;
    end else if (atThree) begin
      dataWrData_ff <= operand_ff + `QPIP_DATA_STEP;
    end
  end

  assign dataAddr = dataAddr_ff;
  assign dataRdEn = phaseTwo && execValid_ff;
  assign dataWrEn = phaseFour && writesFile;
  assign dataWrData = dataWrData_ff;

  // ========================================================================
  // Return address stack
  // The stack wraps silently on the ninth push, overwriting the oldest.
  always_ff @(posedge clk) begin
    if (reset) begin
      sp_ff <= `QPIP_SP_RST;
      for (int i = 0; i < `QPIP_STACK_DEPTH; i++) begin
        stackMem_ff[i] <= `QPIP_PC_RST;
      end
    end else if (atFour && execValid_ff && isCall) begin
      stackMem_ff[sp_ff] <= fetchAddr_ff;
      sp_ff <= sp_ff + `QPIP_SP_STEP;
    end else if (atFour && execValid_ff && isReturn) begin
      sp_ff <= spTop;
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_phase_order: assert property (atOne |=> phaseTwo ##0 (phase_ff == $past(nxt_phase)))
    else $error("Phase one not followed by phase two.");

  a_phase_onehot: assert property ($onehot({phaseOne, phaseTwo, phaseThree, phaseFour}))
    else $error("Phase outputs not one-hot.");

  a_cycle_length: assert property (clkEn [*4] |=> phase_ff == $past(phase_ff, 4))
    else $error("Instruction cycle is not four phases.");

  a_pc_step: assert property (atOne |=> pc_ff == $past(pc_ff) + `QPIP_PC_STEP)
    else $error("Program counter did not step in phase one.");

  a_pc_hold: assert property ((clkEn && (phaseTwo || phaseThree)) |=> pc_ff == $past(pc_ff))
    else $error("Program counter moved outside phase one.");

  a_latch_fetch: assert property (atFour |=> fetchedOpcodeLatch_ff == $past(progData))
    else $error("Fetched word not latched in phase four.");

  a_exec_load: assert property (atOne |=> execOpcode_ff == $past(fetchedOpcodeLatch_ff))
    else $error("Execute stage did not load the fetched word.");

  a_read_phase: assert property ((atTwo && execValid_ff)
    |-> dataRdEn ##1 (operand_ff == $past(dataRdData)))
    else $error("Operand not read in phase two.");

  a_data_addr: assert property (atOne
    |=> dataAddr == $past(fetchedOpcodeLatch_ff[`QPIP_FADDR_HI:0]))
    else $error("File address not loaded in phase one.");

  a_write_phase: assert property (dataWrEn
    |-> phaseFour && execValid_ff && execOpcode_ff[`QPIP_DEST_BIT])
    else $error("Data write outside phase four.");

  a_write_data: assert property (atThree
    |=> dataWrData == $past(operand_ff) + `QPIP_DATA_STEP)
    else $error("Write data is not the operand plus one.");

  a_overlap_run: assert property ((atOne && !flush_ff) |=> execValid_ff)
    else $error("Sequential word not executed.");

  a_branch_target: assert property ((atFour && branchTaken) |=> pc_ff == $past(branchTarget))
    else $error("Branch did not load the target.");

  a_branch_flush: assert property ((atFour && branchTaken)
    |=> flush_ff && phaseOne)
    else $error("Branch did not mark the prefetched word.");

  a_branch_squash: assert property ((atOne && flush_ff) |=> !execValid_ff)
    else $error("Prefetched word was not squashed.");

  a_squash_quiet: assert property (!execValid_ff
    |-> !dataRdEn && !dataWrEn && !branchTaken)
    else $error("Squashed word touched memory or the counter.");

  a_stack_push: assert property ((atFour && execValid_ff && isCall)
    |=> stackMem_ff[$past(sp_ff)] == $past(fetchAddr_ff) && sp_ff == $past(sp_ff) + `QPIP_SP_STEP)
    else $error("Call did not push the return address.");

  a_stack_pop: assert property ((atFour && execValid_ff && isReturn)
    |=> sp_ff == $past(spTop) && pc_ff == $past(stackMem_ff[spTop]))
    else $error("Return did not pop the stack.");

  a_fetch_addr: assert property (atOne |=> progAddr == $past(pc_ff))
    else $error("Fetch address not taken from the counter.");

  a_latch_hold: assert property ((clkEn && !phaseFour)
    |=> $stable(fetchedOpcodeLatch_ff))
    else $error("Fetched word changed outside phase four.");

  a_exec_hold: assert property ((clkEn && !phaseOne)
    |=> $stable(execOpcode_ff) && $stable(execValid_ff))
    else $error("Execute stage changed outside phase one.");

  // A low enable must leave every stage where it was; only reset may move it.
  a_freeze_hold: assert property (!clkEn
    |=> $stable(phase_ff) && $stable(pc_ff) && $stable(sp_ff))
    else $error("State moved while the enable was low.");

  // ========================================================================
  // Cover points
  // The freeze and squash covers matter most: a bench that never holds the
  // enable low leaves the freeze assertion idle; without branches the squash one sees only the word after reset.
  c_write_back: cover property (dataWrEn);
  c_goto_taken: cover property (atFour && branchTaken && isGoto);
  c_call_return: cover property ((atFour && execValid_ff && isCall) ##[1:40] (atFour && execValid_ff && isReturn));
  c_branch_squash: cover property ((atOne && flush_ff) ##1 !execValid_ff);
  c_enable_freeze: cover property (!clkEn ##1 !clkEn);

endmodule // qpip_pipeline

// >>> tb/qpip_mem_model.sv
// Program and data memory facing the instruction pipeline.
// Assumes one clock; the bench loads both arrays directly.
`timescale 1ns/1ns
`include "qpip_defines.svh"

module qpip_mem_model (
  // Clock and enable
  input wire logic clk,
  input wire logic clkEn,
  // Program side
  input wire logic [`QPIP_PC_W-1:0] progAddr,
  output logic [`QPIP_INSTR_W-1:0] progData,
  // Data side
  input wire logic [`QPIP_FADDR_W-1:0] dataAddr,
  input wire logic dataRdEn,
  input wire logic dataWrEn,
  input wire logic [`QPIP_DATA_W-1:0] dataWrData,
  output logic [`QPIP_DATA_W-1:0] dataRdData
);
  logic [`QPIP_INSTR_W-1:0] rom [2**`QPIP_PC_W];
  logic [`QPIP_DATA_W-1:0] ram [2**`QPIP_FADDR_W];
  logic [`QPIP_DATA_W-1:0] lastRd = 8'h5A;
  assign progData = rom[progAddr];
  // An idle read bus shows the inverse of the last word, so stale data never looks right.
  assign dataRdData = dataRdEn ? ram[dataAddr] : ~lastRd;
  always @(posedge clk) begin
    if (dataRdEn) lastRd <= ram[dataAddr];
    if (dataWrEn && clkEn) ram[dataAddr] <= dataWrData;
  end
endmodule // qpip_mem_model

// >>> tb/tb.sv
// Self-checking bench for the quad phase instruction pipeline.
// Assumes the memory model answers combinationally on the same clock.
`timescale 1ns/1ns
`include "qpip_defines.svh"

module tb;
  // ==========================================================================
  // Signals
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic clkEn = 1'h1;
  logic phaseOne, phaseTwo, phaseThree, phaseFour, dataRdEn, dataWrEn, execValid;
  logic [`QPIP_PC_W-1:0] progAddr;
  logic [`QPIP_INSTR_W-1:0] progData, execOpcode;
  logic [`QPIP_FADDR_W-1:0] dataAddr;
  logic [`QPIP_DATA_W-1:0] dataRdData, dataWrData;
  logic [3:0] ph;
  logic [7:0] expRam [128];
  int errorCnt, comparisons;
  // Each row: fetch address, executing word valid, executing word.
  logic [25:0] rows [13] = '{
    {11'h000, 1'h0, 14'h0000}, {11'h001, 1'h1, 14'h0090}, {11'h002, 1'h1, 14'h0091},
    {11'h003, 1'h1, 14'h2805}, {11'h005, 1'h0, 14'h0000}, {11'h006, 1'h1, 14'h0093},
    {11'h007, 1'h1, 14'h2009}, {11'h009, 1'h0, 14'h0000}, {11'h00A, 1'h1, 14'h0008},
    {11'h007, 1'h0, 14'h0000}, {11'h008, 1'h1, 14'h0094}, {11'h009, 1'h1, 14'h2808},
    {11'h008, 1'h0, 14'h0000}};
  // Program image: straight line, a goto, a call into a return and a self loop.
  logic [13:0] prog [10] = '{14'h0090, 14'h0091, 14'h2805, 14'h0092,
    14'h0000, 14'h0093, 14'h2009, 14'h0094, 14'h2808, 14'h0008};
  assign ph = {phaseFour, phaseThree, phaseTwo, phaseOne};

  qpip_pipeline qpip_pipeline_inst (.clk(clk), .reset(reset), .clkEn(clkEn),
    .phaseOne(phaseOne), .phaseTwo(phaseTwo), .phaseThree(phaseThree),
    .phaseFour(phaseFour), .progAddr(progAddr), .progData(progData),
    .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataRdData(dataRdData),
    .dataWrEn(dataWrEn), .dataWrData(dataWrData), .execValid(execValid),
    .execOpcode(execOpcode));
  qpip_mem_model qpip_mem_model_inst (.clk(clk), .clkEn(clkEn), .progAddr(progAddr),
    .progData(progData), .dataAddr(dataAddr), .dataRdEn(dataRdEn),
    .dataWrEn(dataWrEn), .dataWrData(dataWrData), .dataRdData(dataRdData));

  // ==========================================================================
  // Checking
  task automatic checkWord(input string n, input logic [13:0] e, input logic [13:0] s);
    comparisons++;
    if (s !== e) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic printVerdict();
    $display("Checks %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One instruction cycle, entered and left at a falling edge in phase one.
  task automatic runCycle(input logic [25:0] r);
    logic [10:0] fa;
    logic v;
    logic [13:0] op;
    logic wr;
    {fa, v, op} = r;
    wr = v && op[13:12] == 2'h0 && op[7];
    checkWord("phaseOne", 14'h0001, {10'h000, ph});
    @(negedge clk);
    checkWord("phaseTwo", 14'h0002, {10'h000, ph});
    checkWord("dataRdEn", {13'h0000, v}, {13'h0000, dataRdEn});
    if (v) checkWord("dataAddr", {7'h00, op[6:0]}, {7'h00, dataAddr});
    @(negedge clk);
    checkWord("phaseThree", 14'h0004, {10'h000, ph});
    @(negedge clk);
    checkWord("phaseFour", 14'h0008, {10'h000, ph});
    checkWord("progAddr", {3'h0, fa}, {3'h0, progAddr});
    checkWord("execValid", {13'h0000, v}, {13'h0000, execValid});
    if (v) checkWord("execOpcode", op, execOpcode);
    checkWord("dataWrEn", {13'h0000, wr}, {13'h0000, dataWrEn});
    if (wr) begin
      checkWord("dataWrData", {6'h00, expRam[op[6:0]] + 8'h01}, {6'h00, dataWrData});
      expRam[op[6:0]] = expRam[op[6:0]] + 8'h01;
    end
    @(negedge clk);
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (2000) @(posedge clk);
    errorCnt++;
    printVerdict();
  end

  initial begin
    logic [3:0] heldPh;
    logic [10:0] heldAddr;
    foreach (qpip_mem_model_inst.rom[i]) qpip_mem_model_inst.rom[i] = 14'h0000;
    foreach (expRam[i]) expRam[i] = i[7:0];
    expRam[19] = 8'hFF;
    foreach (expRam[i]) qpip_mem_model_inst.ram[i] = expRam[i];
    foreach (prog[i]) qpip_mem_model_inst.rom[i] = prog[i];
    repeat (5) @(negedge clk);
    checkWord("rstPhase", 14'h0001, {10'h000, ph});
    checkWord("rstAddr", 14'h0000, {3'h0, progAddr});
    reset = 1'h0;
    // Branches, a call into a return and a squashed prefetch, then a self loop.
    for (int i = 0; i < 13; i++) runCycle(rows[i]);
    // A low enable must freeze phase and fetch address alike.
    @(negedge clk);
    heldPh = ph;
    heldAddr = progAddr;
    clkEn = 1'h0;
    repeat (6) @(negedge clk);
    checkWord("frozenPhase", {10'h000, heldPh}, {10'h000, ph});
    checkWord("frozenAddr", {3'h0, heldAddr}, {3'h0, progAddr});
    // Reset in mid-run acts even with the enable low, then the run restarts.
    reset = 1'h1;
    @(negedge clk);
    clkEn = 1'h1;
    reset = 1'h0;
    checkWord("rstValid", 14'h0000, {13'h0000, execValid});
    for (int i = 0; i < 4; i++) runCycle(rows[i]);
    printVerdict();
  end
endmodule // tb
